/* include/ers_pkg.sv */
/*
 * Constants, register map and timing figures shared by the receive
 * alignment status page. Assumes a single 100 MHz clock domain.
 */
//
// Contract
// - Bit 7 of the sync status word shows basic frame alignment, one for lost, zero for acquired.
// - Bit 6 shows signalling multiframe alignment, one for lost, zero for acquired.
// - Bit 5 shows CRC-4 multiframe alignment, one for lost, zero for acquired.
// - Bit 4 holds the E1 bit received in the last CRC-4 multiframe.
// - Bit 3 holds the E2 bit received in the last CRC-4 multiframe.
// - Bit 2 sets when CRC-4 multiframe alignment is not found within 8 ms of basic alignment.
// - A set reframe flag forces a new basic frame search if maintenance is on and auto interworking is off.
// - Bit 1 rises after basic alignment is lost for 100 ms and falls as soon as it is regained.
// - Bit 0 shows CRC-4 interworking, one for CRC-to-CRC, zero for CRC-to-non-CRC.
// - The status words sit at 10H to 1AH in the documented order, and 1BH to 1EH are unused.
package ers_pkg;

    //******************************
    // Widths
    //******************************
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned IDX_W  = 4;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned CNT_W  = 24;

    //******************************
    // Status page map (A4..A0)
    //******************************
    localparam logic [ADDR_W-1:0] ADDR_SYNC_STATUS   = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_RX_FRAME_AL   = 5'h11;
    localparam logic [ADDR_W-1:0] ADDR_TIMER_STATUS  = 5'h12;
    localparam logic [ADDR_W-1:0] ADDR_RX_NONFRAME   = 5'h13;
    localparam logic [ADDR_W-1:0] ADDR_RX_MULTIFRAME = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_HIGH    = 5'h15;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_LOW     = 5'h16;
    localparam logic [ADDR_W-1:0] ADDR_JITTER_BUF    = 5'h17;
    localparam logic [ADDR_W-1:0] ADDR_SIGNAL_LEVEL  = 5'h18;
    localparam logic [ADDR_W-1:0] ADDR_ALARM_ONE     = 5'h19;
    localparam logic [ADDR_W-1:0] ADDR_SPARE_CHANGE  = 5'h1A;
    localparam logic [ADDR_W-1:0] ADDR_IDENT         = 5'h1F;
    // Bit A4 selects this page within the 32-address window
    localparam int unsigned PAGE_SEL_BIT = 4;

    // Arbitrary neutral identification value
    localparam logic [DATA_W-1:0] IDENT_VALUE = 8'h5C;
    localparam logic [DATA_W-1:0] WORD_ZERO   = 8'h00;

    //******************************
    // Sync status word fields
    //******************************
    localparam int unsigned BIT_BASIC_LOSS  = 7;
    localparam int unsigned BIT_SIG_MF_LOSS = 6;
    localparam int unsigned BIT_CRC_MF_LOSS = 5;
    localparam int unsigned BIT_E_ONE       = 4;
    localparam int unsigned BIT_E_TWO       = 3;
    localparam int unsigned BIT_REFRAME     = 2;
    localparam int unsigned BIT_FRAME_ALARM = 1;
    localparam int unsigned BIT_INTERWORK   = 0;

    //******************************
    // Timing
    //******************************
    localparam int unsigned CLK_KHZ        = 100_000;
    localparam int unsigned CRC_TMO_MS     = 8;
    localparam int unsigned ALARM_MS       = 100;
    localparam int unsigned CRC_TMO_CYC    = CRC_TMO_MS * CLK_KHZ;
    localparam int unsigned ALARM_CYC      = ALARM_MS * CLK_KHZ;

endpackage : ers_pkg

/* design/ers_stat_mem.sv */
/*
 * Small status page memory: one write port, one read port with the read
 * data held in a register. Assumes the writer refreshes every word.
 */
`timescale 1ns/100ps

module ers_stat_mem
    import ers_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_wr_en,
    input  wire logic [IDX_W-1:0]  i_wr_idx,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_rd_en,
    input  wire logic              i_rd_blank,
    input  wire logic [IDX_W-1:0]  i_rd_idx,
    output logic      [DATA_W-1:0] o_rd_data
);

    logic [DATA_W-1:0] mem_r [0:(1<<IDX_W)-1];
    logic [DATA_W-1:0] q_r;

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_r[i_wr_idx] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q_r <= WORD_ZERO;
        end else if (i_rd_en) begin
            q_r <= i_rd_blank ? WORD_ZERO : mem_r[i_rd_idx];
        end
    end

    assign o_rd_data = q_r;

endmodule // ers_stat_mem

/* design/ers_sync_status.sv */
/*
 * Receive alignment status logic and read-only status page of an E1
 * framer. Assumes the framer core runs on i_clk and hands over its
 * alignment levels, E-bits and per-multiframe strobe on that clock.
 */
`timescale 1ns/100ps

module ers_sync_status
    import ers_pkg::*;
#(
    parameter int unsigned P_CRC_TMO_CYC = CRC_TMO_CYC,
    parameter int unsigned P_ALARM_CYC   = ALARM_CYC
)
(
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    // Alignment levels from the framer core
    input  wire logic              i_basic_aligned,
    input  wire logic              i_sig_mf_aligned,
    input  wire logic              i_crc_mf_aligned,
    input  wire logic              i_crc_mf_end,
    input  wire logic              i_e_bit_one,
    input  wire logic              i_e_bit_two,
    input  wire logic              i_far_end_crc4,
    // Configuration from the control page
    input  wire logic              i_maint_option,
    input  wire logic              i_auto_interwork,
    // Other live status words of the page
    input  wire logic [DATA_W-1:0] i_rx_frame_align_word,
    input  wire logic [DATA_W-1:0] i_timer_status_word,
    input  wire logic [DATA_W-1:0] i_rx_nonframe_align_word,
    input  wire logic [DATA_W-1:0] i_rx_multiframe_align_word,
    input  wire logic [DATA_W-1:0] i_phase_status_high,
    input  wire logic [DATA_W-1:0] i_phase_status_low,
    input  wire logic [DATA_W-1:0] i_jitter_buffer_status,
    input  wire logic [DATA_W-1:0] i_rx_signal_level_status,
    input  wire logic [DATA_W-1:0] i_alarm_status_one,
    input  wire logic [DATA_W-1:0] i_spare_bit_change_report,
    // Status page read port
    input  wire logic              i_rd_en,
    input  wire logic [ADDR_W-1:0] i_rd_addr,
    output logic      [DATA_W-1:0] o_rd_data,
    output logic                   o_rd_valid,
    // Direct status to the framer core
    output logic      [DATA_W-1:0] o_sync_status_word,
    output logic                   o_force_reframe
);

    //******************************
    // Local constants
    //******************************
    localparam logic [CNT_W-1:0] CRC_TMO_LAST = CNT_W'(P_CRC_TMO_CYC - 1);
    localparam logic [CNT_W-1:0] ALARM_LAST   = CNT_W'(P_ALARM_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO     = 24'h00_0000;
    localparam logic [CNT_W-1:0] CNT_ONE      = 24'h00_0001;
    localparam logic [IDX_W-1:0] IDX_ONE      = 4'h1;
    localparam logic [IDX_W-1:0] IDX_ZERO     = 4'h0;

    //******************************
    // State machine for the CRC-4 search window
    //******************************
    typedef enum logic [1:0] {
        ERS_ST_NO_BASIC = 2'b00,
        ERS_ST_SEARCH   = 2'b01,
        ERS_ST_TIMEOUT  = 2'b10,
        ERS_ST_CRC_OK   = 2'b11
    } ers_crc_st_e;

    // Saturating step of a persistence counter
    function automatic logic [CNT_W-1:0] ers_step(
        input logic [CNT_W-1:0] cnt,
        input logic [CNT_W-1:0] last
    );
        ers_step = (cnt == last) ? cnt : cnt + CNT_ONE;
    endfunction

    //******************************
    // Declarations
    //******************************
    ers_crc_st_e       crc_st_r;
    ers_crc_st_e       crc_st_nxt;
    logic [CNT_W-1:0]  crc_cnt_r;
    logic [CNT_W-1:0]  crc_cnt_nxt;
    logic [CNT_W-1:0]  loss_cnt_r;
    logic [CNT_W-1:0]  loss_cnt_nxt;
    logic              basic_loss_r;
    logic              sig_mf_loss_r;
    logic              crc_mf_loss_r;
    logic              received_e_bit_one_r;
    logic              received_e_bit_two_r;
    logic              crc4_reframe_flag_r;
    logic              crc4_reframe_flag_nxt;
    logic              frame_loss_alarm_r;
    logic              frame_loss_alarm_nxt;
    logic              crc4_interworking_state_r;
    logic              force_reframe_r;
    logic              rd_valid_r;
    logic [IDX_W-1:0]  scan_r;
    logic [DATA_W-1:0] scan_word;
    logic [DATA_W-1:0] sync_word;
    wire               crc_timeout;
    wire               alarm_reached;
    wire               reframe_set;
    wire               reframe_clear;
    wire               reframe_allowed;
    wire               rd_off_page;

    //******************************
    // Alignment levels
    //******************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            basic_loss_r              <= 1'b1;
            sig_mf_loss_r             <= 1'b1;
            crc_mf_loss_r             <= 1'b1;
            crc4_interworking_state_r <= 1'b0;
        end else begin
            basic_loss_r              <= ~i_basic_aligned;
            sig_mf_loss_r             <= ~i_sig_mf_aligned;
            crc_mf_loss_r             <= ~i_crc_mf_aligned;
            crc4_interworking_state_r <= i_far_end_crc4;
        end
    end

    //******************************
    // Received E-bits
    //******************************
    // Captured only at the multiframe boundary so software never sees a
    // mix of two multiframes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            received_e_bit_one_r <= 1'b0;
            received_e_bit_two_r <= 1'b0;
        end else if (i_crc_mf_end) begin
            received_e_bit_one_r <= i_e_bit_one;
            received_e_bit_two_r <= i_e_bit_two;
        end
    end

    //******************************
    // CRC-4 search window and reframe
    //******************************
    assign crc_timeout = (crc_st_r == ERS_ST_SEARCH) && (crc_cnt_r == CRC_TMO_LAST);

    always_comb begin
        crc_st_nxt  = crc_st_r;
        crc_cnt_nxt = crc_cnt_r;
        case (crc_st_r)
            ERS_ST_NO_BASIC: begin
                crc_cnt_nxt = CNT_ZERO;
                if (i_basic_aligned) begin
                    crc_st_nxt = ERS_ST_SEARCH;
                end
            end
            ERS_ST_SEARCH: begin
                crc_cnt_nxt = ers_step(crc_cnt_r, CRC_TMO_LAST);
                if (!i_basic_aligned) begin
                    crc_st_nxt = ERS_ST_NO_BASIC;
                end else if (i_crc_mf_aligned) begin
                    crc_st_nxt = ERS_ST_CRC_OK;
                end else if (crc_timeout) begin
                    crc_st_nxt = ERS_ST_TIMEOUT;
                end
            end
            ERS_ST_TIMEOUT: begin
                crc_cnt_nxt = CNT_ZERO;
                if (!i_basic_aligned) begin
                    crc_st_nxt = ERS_ST_NO_BASIC;
                end else if (i_crc_mf_aligned) begin
                    crc_st_nxt = ERS_ST_CRC_OK;
                end
            end
            ERS_ST_CRC_OK: begin
                crc_cnt_nxt = CNT_ZERO;
                if (!i_basic_aligned) begin
                    crc_st_nxt = ERS_ST_NO_BASIC;
                end else if (!i_crc_mf_aligned) begin
                    crc_st_nxt = ERS_ST_SEARCH;
                end
            end
            default: begin
                crc_st_nxt  = ERS_ST_NO_BASIC;
                crc_cnt_nxt = CNT_ZERO;
            end
        endcase
    end

    // Flag holds until CRC-4 alignment is found or basic alignment drops;
    // a clear in the same cycle as a timeout wins
    assign reframe_set     = crc_timeout && !i_crc_mf_aligned && i_basic_aligned;
    assign reframe_clear   = i_crc_mf_aligned || !i_basic_aligned;
    assign reframe_allowed = i_maint_option && !i_auto_interwork;

    always_comb begin
        crc4_reframe_flag_nxt = crc4_reframe_flag_r;
        if (reframe_set) begin
            crc4_reframe_flag_nxt = 1'b1;
        end else if (reframe_clear) begin
            crc4_reframe_flag_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            crc_st_r            <= ERS_ST_NO_BASIC;
            crc_cnt_r           <= CNT_ZERO;
            crc4_reframe_flag_r <= 1'b0;
            force_reframe_r     <= 1'b0;
        end else begin
            crc_st_r            <= crc_st_nxt;
            crc_cnt_r           <= crc_cnt_nxt;
            crc4_reframe_flag_r <= crc4_reframe_flag_nxt;
            force_reframe_r     <= reframe_set && reframe_allowed;
        end
    end

    //******************************
    // Frame loss alarm
    //******************************
    // Counter restarts on every regain, so short glitches of alignment
    // never accumulate towards the alarm
    assign alarm_reached = (loss_cnt_r == ALARM_LAST) && !i_basic_aligned;

    always_comb begin
        loss_cnt_nxt         = CNT_ZERO;
        frame_loss_alarm_nxt = 1'b0;
        if (!i_basic_aligned) begin
            loss_cnt_nxt         = ers_step(loss_cnt_r, ALARM_LAST);
            frame_loss_alarm_nxt = frame_loss_alarm_r || alarm_reached;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            loss_cnt_r         <= CNT_ZERO;
            frame_loss_alarm_r <= 1'b0;
        end else begin
            loss_cnt_r         <= loss_cnt_nxt;
            frame_loss_alarm_r <= frame_loss_alarm_nxt;
        end
    end

    //******************************
    // Synchronization status word
    //******************************
    always_comb begin
        sync_word                  = WORD_ZERO;
        sync_word[BIT_BASIC_LOSS]  = basic_loss_r;
        sync_word[BIT_SIG_MF_LOSS] = sig_mf_loss_r;
        sync_word[BIT_CRC_MF_LOSS] = crc_mf_loss_r;
        sync_word[BIT_E_ONE]       = received_e_bit_one_r;
        sync_word[BIT_E_TWO]       = received_e_bit_two_r;
        sync_word[BIT_REFRAME]     = crc4_reframe_flag_r;
        sync_word[BIT_FRAME_ALARM] = frame_loss_alarm_r;
        sync_word[BIT_INTERWORK]   = crc4_interworking_state_r;
    end

    //******************************
    // Page refresh scan
    //******************************
    // One word is refreshed per cycle; a read may see a word up to
    // sixteen cycles old, which is far below any framing event rate
    always_comb begin
        case ({1'b1, scan_r})
            ADDR_SYNC_STATUS:   scan_word = sync_word;
            ADDR_RX_FRAME_AL:   scan_word = i_rx_frame_align_word;
            ADDR_TIMER_STATUS:  scan_word = i_timer_status_word;
            ADDR_RX_NONFRAME:   scan_word = i_rx_nonframe_align_word;
            ADDR_RX_MULTIFRAME: scan_word = i_rx_multiframe_align_word;
            ADDR_PHASE_HIGH:    scan_word = i_phase_status_high;
            ADDR_PHASE_LOW:     scan_word = i_phase_status_low;
            ADDR_JITTER_BUF:    scan_word = i_jitter_buffer_status;
            ADDR_SIGNAL_LEVEL:  scan_word = i_rx_signal_level_status;
            ADDR_ALARM_ONE:     scan_word = i_alarm_status_one;
            ADDR_SPARE_CHANGE:  scan_word = i_spare_bit_change_report;
            ADDR_IDENT:         scan_word = IDENT_VALUE;
            default:            scan_word = WORD_ZERO;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            scan_r <= IDX_ZERO;
        end else begin
            scan_r <= scan_r + IDX_ONE;
        end
    end

    //******************************
    // Read port
    //******************************
    // Software has no write path into the page; only the refresh scan writes it
    assign rd_off_page = !i_rd_addr[PAGE_SEL_BIT];

    ers_stat_mem u_stat_mem (
        .i_clk      (i_clk),
        .i_nrst     (i_nrst),
        .i_wr_en    (1'b1),
        .i_wr_idx   (scan_r),
        .i_wr_data  (scan_word),
        .i_rd_en    (i_rd_en),
        .i_rd_blank (rd_off_page),
        .i_rd_idx   (i_rd_addr[IDX_W-1:0]),
        .o_rd_data  (o_rd_data)
    );

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= i_rd_en;
        end
    end

    //******************************
    // Outputs
    //******************************
    assign o_rd_valid         = rd_valid_r;
    assign o_sync_status_word = sync_word;
    assign o_force_reframe    = force_reframe_r;

endmodule // ers_sync_status

/* verif/ers_sync_status_monitor.sv */
/* Assertion checker for ers_sync_status, bound to the top ports.
   Assumes one clock domain and the timeout parameters of the bound instance. */
`timescale 1ns/100ps
module ers_sync_status_monitor
    import ers_pkg::*;
#(
    parameter int unsigned P_CRC_TMO_CYC = CRC_TMO_CYC,
    parameter int unsigned P_ALARM_CYC   = ALARM_CYC
)
(
    input wire logic              i_clk,
    input wire logic              i_nrst,
    input wire logic              i_basic_aligned,
    input wire logic              i_sig_mf_aligned,
    input wire logic              i_crc_mf_aligned,
    input wire logic              i_crc_mf_end,
    input wire logic              i_e_bit_one,
    input wire logic              i_e_bit_two,
    input wire logic              i_far_end_crc4,
    input wire logic              i_maint_option,
    input wire logic              i_auto_interwork,
    input wire logic              i_rd_en,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    input wire logic [DATA_W-1:0] o_rd_data,
    input wire logic              o_rd_valid,
    input wire logic [DATA_W-1:0] o_sync_status_word,
    input wire logic              o_force_reframe
);
    //******************************
    // Run-length counters of search and loss
    //******************************
    // Full counter width, so full-length timeouts are never outrun by a wrap
    logic [CNT_W-1:0] srch_r;
    logic [CNT_W-1:0] loss_r;
    logic [7:0]       w;
    assign w = o_sync_status_word;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            srch_r <= 24'h00_0000;
            loss_r <= 24'h00_0000;
        end else begin
            srch_r <= (i_basic_aligned && !i_crc_mf_aligned) ?
                      srch_r + 24'h00_0001 : 24'h00_0000;
            loss_r <= i_basic_aligned ? 24'h00_0000 : loss_r + 24'h00_0001;
        end
    end
    //******************************
    // Properties
    //******************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_rd_req;
        i_rd_en ##1 o_rd_valid;
    endsequence
    chk_basic_loss_bit: assert property ($past(i_nrst) |-> w[7] == !$past(i_basic_aligned))
        else $error("basic loss bit wrong");
    chk_sig_loss_bit: assert property ($past(i_nrst) |-> w[6] == !$past(i_sig_mf_aligned))
        else $error("signalling loss bit wrong");
    chk_crc_loss_bit: assert property ($past(i_nrst) |-> w[5] == !$past(i_crc_mf_aligned))
        else $error("crc loss bit wrong");
    chk_ebit_capture: assert property (i_crc_mf_end |=>
        w[4:3] == {$past(i_e_bit_one), $past(i_e_bit_two)}) else $error("e-bits not captured");
    chk_ebit_hold: assert property ($past(i_nrst) && !i_crc_mf_end |=> $stable(w[4:3]))
        else $error("e-bits moved off strobe");
    chk_reframe_late: assert property ($rose(w[2]) |-> srch_r >= P_CRC_TMO_CYC)
        else $error("reframe flag too early");
    chk_reframe_due: assert property (srch_r == P_CRC_TMO_CYC + 4 |-> w[2])
        else $error("reframe flag missing");
    chk_force_gate: assert property ($past(i_nrst) |-> o_force_reframe == ($rose(w[2]) &&
        $past(i_maint_option) && !$past(i_auto_interwork))) else $error("force pulse wrong");
    chk_alarm_early: assert property ($rose(w[1]) |-> loss_r >= P_ALARM_CYC)
        else $error("alarm too early");
    chk_alarm_due: assert property (loss_r == P_ALARM_CYC + 3 |-> w[1])
        else $error("alarm missing");
    chk_alarm_clear: assert property (i_basic_aligned |=> !w[1])
        else $error("alarm not cleared");
    chk_interwork_bit: assert property ($past(i_nrst) |-> w[0] == $past(i_far_end_crc4))
        else $error("interworking bit wrong");
    chk_ident_read: assert property (i_rd_en && i_rd_addr == ADDR_IDENT
        |-> s_rd_req ##0 o_rd_data == IDENT_VALUE) else $error("ident read wrong");
    chk_unused_zero: assert property (i_rd_en && (!i_rd_addr[4] || (i_rd_addr > 5'h1A &&
        i_rd_addr < 5'h1F)) |-> s_rd_req ##0 o_rd_data == 8'h00) else $error("unused not zero");
    chk_rd_hold: assert property ($past(i_nrst) && !i_rd_en |=> !o_rd_valid && $stable(o_rd_data))
        else $error("read port moved without strobe");
endmodule // ers_sync_status_monitor

bind ers_sync_status ers_sync_status_monitor #(
    .P_CRC_TMO_CYC(P_CRC_TMO_CYC),
    .P_ALARM_CYC(P_ALARM_CYC)
) u_mon (.i_clk, .i_nrst, .i_basic_aligned, .i_sig_mf_aligned, .i_crc_mf_aligned,
    .i_crc_mf_end, .i_e_bit_one, .i_e_bit_two, .i_far_end_crc4, .i_maint_option,
    .i_auto_interwork, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid,
    .o_sync_status_word, .o_force_reframe);

/* verif/ers_far_end_model.sv */
/* Far-end line model: the framer core view of a remote E1 terminal.
   Assumes the bench changes its commands just after a rising clock edge. */
`timescale 1ns/100ps
module ers_far_end_model (
    input  wire logic       i_clk,
    input  wire logic       i_basic_cmd,
    input  wire logic       i_sig_cmd,
    input  wire logic       i_crc_cmd,
    input  wire logic [1:0] i_ebit_cmd,
    output logic            o_basic_aligned,
    output logic            o_sig_mf_aligned,
    output logic            o_crc_mf_aligned,
    output logic            o_crc_mf_end,
    output logic            o_e_bit_one,
    output logic            o_e_bit_two,
    output logic            o_far_end_crc4
);
    // Shortened multiframe: one end strobe every 16 cycles
    logic [3:0] phase_r = 4'h0;
    always_ff @(posedge i_clk) begin
        phase_r <= phase_r + 4'h1;
    end
    assign o_basic_aligned  = i_basic_cmd;
    assign o_sig_mf_aligned = i_basic_cmd & i_sig_cmd;
    assign o_crc_mf_aligned = i_basic_cmd & i_crc_cmd;
    assign o_far_end_crc4   = i_crc_cmd;
    assign o_crc_mf_end     = (phase_r == 4'hF);
    // Off the strobe the E-bits show the inverse, so a late sample is caught
    assign o_e_bit_one = o_crc_mf_end ? i_ebit_cmd[1] : ~i_ebit_cmd[1];
    assign o_e_bit_two = o_crc_mf_end ? i_ebit_cmd[0] : ~i_ebit_cmd[0];
endmodule // ers_far_end_model

/* verif/ers_sync_status_bench.sv */
/* Self-checking bench for ers_sync_status driven through a far-end model.
   Assumes shortened timeouts so each timed behaviour runs in tens of cycles. */
`timescale 1ns/100ps
module ers_sync_status_bench;
    import ers_pkg::*;
    localparam int TMO = 20;
    localparam int ALM = 30;
    logic       i_clk;
    logic       i_nrst;
    logic       basic_cmd, sig_cmd, crc_cmd, maint, auto_iw, rd_en;
    logic [1:0] eb_cmd;
    logic [4:0] rd_addr;
    logic [7:0] words [10];
    logic [7:0] rd_data, sync_word;
    logic       rd_valid, force_rf, basic, sig, crc, mf_end, e1, e2, fe;
    int         fails = 0;
    int         comparisons = 0;

    ers_far_end_model u_far (.i_clk(i_clk), .i_basic_cmd(basic_cmd), .i_sig_cmd(sig_cmd),
        .i_crc_cmd(crc_cmd), .i_ebit_cmd(eb_cmd), .o_basic_aligned(basic),
        .o_sig_mf_aligned(sig), .o_crc_mf_aligned(crc), .o_crc_mf_end(mf_end),
        .o_e_bit_one(e1), .o_e_bit_two(e2), .o_far_end_crc4(fe));
    ers_sync_status #(.P_CRC_TMO_CYC(TMO), .P_ALARM_CYC(ALM)) uut (.i_clk(i_clk),
        .i_nrst(i_nrst), .i_basic_aligned(basic), .i_sig_mf_aligned(sig),
        .i_crc_mf_aligned(crc), .i_crc_mf_end(mf_end), .i_e_bit_one(e1), .i_e_bit_two(e2),
        .i_far_end_crc4(fe), .i_maint_option(maint), .i_auto_interwork(auto_iw),
        .i_rx_frame_align_word(words[0]), .i_timer_status_word(words[1]),
        .i_rx_nonframe_align_word(words[2]), .i_rx_multiframe_align_word(words[3]),
        .i_phase_status_high(words[4]), .i_phase_status_low(words[5]),
        .i_jitter_buffer_status(words[6]), .i_rx_signal_level_status(words[7]),
        .i_alarm_status_one(words[8]), .i_spare_bit_change_report(words[9]),
        .i_rd_en(rd_en), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_rd_valid(rd_valid),
        .o_sync_status_word(sync_word), .o_force_reframe(force_rf));

    //******************************
    // Shared tasks
    //******************************
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic cmp8(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic cmp_rng(input string name, input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi) begin
            fails++;
            $display("Error %s expected %0d to %0d seen %0d", name, lo, hi, got);
        end
    endtask
    // One strobe per read; the strobe drops one edge before the next read
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        tick(1);
        rd_en = 1'b1;
        rd_addr = a;
        tick(1);
        rd_en = 1'b0;
        cmp8("read valid", 8'h01, {7'h00, rd_valid});
        cmp8("read data", exp, rd_data);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    //******************************
    // Scenarios
    //******************************
    task automatic t_align();
        logic [7:0] exp [2] = '{8'h11, 8'h49};
        for (int k = 0; k < 2; k++) begin
            basic_cmd = 1'b1;
            crc_cmd = 1'b1;
            sig_cmd = (k == 0);
            eb_cmd = (k == 0) ? 2'b10 : 2'b01;
            tick(40);
            cmp8("sync word", exp[k], sync_word);
            rd(ADDR_SYNC_STATUS, exp[k]);
        end
        $display("test align done");
    endtask
    task automatic t_page();
        for (int k = 0; k < 10; k++) rd(ADDR_RX_FRAME_AL + 5'(k), words[k]);
        for (int a = 'h1B; a < 'h1F; a++) rd(5'(a), 8'h00);
        rd(5'h05, 8'h00);
        rd(ADDR_IDENT, IDENT_VALUE);
        $display("test page done");
    endtask
    task automatic t_reframe();
        int n;
        maint = 1'b1;
        crc_cmd = 1'b0;
        basic_cmd = 1'b0;
        tick(3);
        basic_cmd = 1'b1;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (force_rf !== 1'b1 && n < 60);
        cmp_rng("reframe delay", n, TMO, TMO + 4);
        cmp8("reframe flag", 8'h04, sync_word & 8'h04);
        $display("test reframe done");
    endtask
    task automatic t_alarm();
        int n;
        int pulses;
        auto_iw = 1'b1;
        basic_cmd = 1'b0;
        n = 0;
        do begin
            tick(1);
            n++;
        end while (sync_word[1] !== 1'b1 && n < 80);
        cmp_rng("alarm delay", n, ALM, ALM + 3);
        cmp8("loss bits", 8'hE2, sync_word & 8'hE6);
        basic_cmd = 1'b1;
        tick(2);
        cmp8("alarm clear", 8'h00, sync_word & 8'h82);
        pulses = 0;
        for (int k = 0; k < TMO + 6; k++) begin
            tick(1);
            if (force_rf !== 1'b0) pulses++;
        end
        cmp_rng("force pulses", pulses, 0, 0);
        cmp8("flag no force", 8'h04, sync_word & 8'h06);
        $display("test alarm done");
    endtask

    //******************************
    // Clock, watchdog and main sequence
    //******************************
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        #20000;
        fails++;
        conclude();
    end
    initial begin
        i_nrst = 1'b0;
        {basic_cmd, sig_cmd, crc_cmd, maint, auto_iw, rd_en} = 6'h00;
        eb_cmd = 2'b00;
        rd_addr = 5'h00;
        for (int k = 0; k < 10; k++) words[k] = 8'(8'h31 + 8'h13 * k);
        tick(2);
        cmp8("reset word", 8'hE0, sync_word);
        i_nrst = 1'b1;
        t_align();
        t_page();
        t_reframe();
        t_alarm();
        conclude();
    end
endmodule // ers_sync_status_bench
